// >>> common/rx_afc_pkg.sv
// Purpose: Shared constants for the receive correction and timeout bank.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Offsets below are register indices; byte address is index * 4.
//
// What this block does
// - Writing one to control bit 4 launches a gain control sequence.
// - Control bit 1 set clears correction in receive mode; reads zero.
// - Auto-clear bit 0 clears correction at each auto phase start.
// - Correction: 16-bit two's complement, high 0x1b, low 0x1c, writable.
// - Measured frequency error is 16-bit two's complement at 0x1d and 0x1e.
// - Config bit 7 enables detector; gain phase settings override it.
// - Bits 6-5 pick one, two or three preamble bytes; default field 0x02.
// - Bits 4-0 set chip errors tolerated over preamble, four chips per bit.
// - No signal-level event within value*16 bit periods: timeout; 0 off.
// - No preamble event within value*16 bit periods: timeout; 0 off.
// - No sync match within value*16 bit periods: timeout; 0 off.
package rx_afc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int TMO_W = 12;
  localparam int TMO_SHIFT = 4;

  localparam logic [IDX_W-1:0] IDX_RES_A = 6'h17;
  localparam logic [IDX_W-1:0] IDX_RES_B = 6'h18;
  localparam logic [IDX_W-1:0] IDX_RES_C = 6'h19;
  localparam logic [IDX_W-1:0] IDX_CORR_CTRL = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_CORR_HIGH = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_CORR_LOW = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_ERR_HIGH = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_ERR_LOW = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_PRE_CFG = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_TMO_LEVEL = 6'h20;
  localparam logic [IDX_W-1:0] IDX_TMO_PRE = 6'h21;
  localparam logic [IDX_W-1:0] IDX_TMO_SYNC = 6'h22;

  localparam logic [7:0] RES_A_RESET = 8'h47;
  localparam logic [7:0] RES_B_RESET = 8'h32;
  localparam logic [7:0] RES_C_RESET = 8'h3e;
  localparam logic [7:0] PRE_CFG_RESET = 8'h40;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam int CTRL_GAIN_BIT = 4;
  localparam int CTRL_RSVD_BIT = 3;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int PRE_EN_BIT = 7;
  localparam int PRE_LEN_HI = 6;
  localparam int PRE_LEN_LO = 5;
  localparam int PRE_TOL_HI = 4;
  localparam int PRE_TOL_LO = 0;
endpackage : rx_afc_pkg

// >>> common/rx_timeout_if.sv
// Purpose: Carries one receive timeout channel between bank and counter.
// Assumes: All signals on the register clock.
// Notes: None.
`timescale 1ns/10ps
interface rx_timeout_if;
  logic rx_entry;
  logic bit_tick;
  logic awaited_event;
  logic [7:0] limit;
  logic expired;
  modport ctrl (output rx_entry, bit_tick, awaited_event, limit,
                input expired);
  modport cnt (input rx_entry, bit_tick, awaited_event, limit,
               output expired);
endinterface : rx_timeout_if

// >>> verif/apb_host_model.sv
// Purpose: Host software model driving the bank over APB.
// Assumes: Called right after a clock edge or off it.
// Notes: Waits for pready with no latency assumed.
`timescale 1ns/10ps
module apb_host_model (
  // Clock
  input wire logic ref_clk_in,
  // APB master
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  initial begin
    {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  end

  // A hung slave is cut short only by the bench watchdog.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d, output logic [31:0] q,
                      output logic e);
    logic wr;
    wr = w;
    // Software never disturbs the reserved registers, so a write there
    // is turned into a harmless read.
    if (a inside {8'h5c, 8'h60, 8'h64}) wr = 1'b0;
    @(posedge ref_clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= {24'h000000, d};
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_in !== 1'b1) @(posedge ref_clk_in);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer
endmodule : apb_host_model

// >>> verif/rx_afc_chk.sv
// Purpose: Port-level checks on the correction and timeout bank.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound to every instance of the bank.
`timescale 1ns/10ps
module rx_afc_chk (
  // Watched ports
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic rx_mode_in,
  input wire logic bit_tick_in,
  input wire logic gain_phase_in,
  input wire logic gain_preamble_en_in,
  input wire logic gain_seq_trigger_out,
  input wire logic [15:0] freq_correction_value_out,
  input wire logic preamble_detector_en_out,
  input wire logic timeout_irq_out
);
  logic commit;
  assign commit = psel_in & penable_in & pready_out & pwrite_in;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_trig_pulse: assert property (
    commit && paddr_in[7:2] == 6'h1a && pwdata_in[4] |=> gain_seq_trigger_out)
    else $error("gain trigger missing after write");
  a_trig_cause: assert property (
    gain_seq_trigger_out |-> $past(commit) && $past(pwdata_in[4]))
    else $error("gain trigger without a write");
  a_ctrl_read: assert property (
    pready_out && !pwrite_in && paddr_in[7:2] == 6'h1a |->
    prdata_out[7:4] == 4'h0 && prdata_out[2:1] == 2'h0)
    else $error("control write-only bits read nonzero");
  a_gain_override: assert property (
    gain_phase_in |=> preamble_detector_en_out == $past(gain_preamble_en_in))
    else $error("gain phase did not override detector enable");
  a_corr_write: assert property (
    commit && paddr_in[7:2] == 6'h1b |->
    ##2 freq_correction_value_out[15:8] == $past(pwdata_in[7:0], 2))
    else $error("correction high byte not applied");
  a_corr_clear: assert property (
    commit && paddr_in[7:2] == 6'h1a && pwdata_in[1] && rx_mode_in |->
    ##[1:3] freq_correction_value_out == 16'h0000)
    else $error("correction not cleared in receive mode");
  a_irq_pulse: assert property (
    timeout_irq_out |=> !timeout_irq_out)
    else $error("timeout pulse longer than one cycle");
  a_irq_tick: assert property (
    timeout_irq_out |-> $past(bit_tick_in, 2))
    else $error("timeout not two cycles after a bit tick");
  a_entry_quiet: assert property (
    $rose(rx_mode_in) |-> ##3 !timeout_irq_out [*8])
    else $error("timeout too soon after receive entry");
endmodule : rx_afc_chk

bind rx_afc_preamble_timeout_regs rx_afc_chk chk (
  .ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .rx_mode_in, .bit_tick_in,
  .gain_phase_in, .gain_preamble_en_in, .gain_seq_trigger_out,
  .freq_correction_value_out, .preamble_detector_en_out, .timeout_irq_out
);

// >>> verif/rx_afc_preamble_timeout_regs_tb.sv
// Purpose: Self-checking bench for the correction and timeout bank.
// Assumes: 20 MHz clock, reset held four cycles.
// Notes: Update and error values are tied; their strobes are driven.
`timescale 1ns/10ps
module rx_afc_preamble_timeout_regs_tb;
  import rx_afc_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] q;
    logic e;
  } row_t;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, e;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic rx_mode_in = 1'b0;
  logic bit_tick_in = 1'b0;
  logic gain_phase_in = 1'b0;
  logic gain_preamble_en_in = 1'b0;
  logic auto_correction_en_in = 1'b0;
  logic correction_phase_start_in = 1'b0;
  logic correction_update_in = 1'b0;
  logic freq_error_valid_in = 1'b0;
  logic [2:0] evt = 3'h0;
  logic gain_seq_trigger_out, preamble_detector_en_out, timeout_irq_out;
  logic [1:0] preamble_detect_length_out;
  logic [4:0] preamble_chip_error_tolerance_out;
  logic [15:0] freq_correction_value_out;
  int errors = 0;
  int compares = 0;
  int trigs = 0;
  int irqs = 0;
  int ticks = 0;
  int at = 0;
  int n0;
  row_t rows [19] = '{
    '{8'h5c, 1'b0, 8'h00, 8'h47, 1'b0}, '{8'h60, 1'b0, 8'h00, 8'h32, 1'b0},
    '{8'h64, 1'b0, 8'h00, 8'h3e, 1'b0}, '{8'h5c, 1'b1, 8'h00, 8'h47, 1'b0},
    '{8'h68, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h6c, 1'b0, 8'h00, 8'h00, 1'b0},
    '{8'h70, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h74, 1'b0, 8'h00, 8'h00, 1'b0},
    '{8'h78, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h7c, 1'b0, 8'h00, 8'h40, 1'b0},
    '{8'h80, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h84, 1'b0, 8'h00, 8'h00, 1'b0},
    '{8'h88, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h68, 1'b1, 8'hff, 8'h09, 1'b0},
    '{8'h6c, 1'b1, 8'h80, 8'h80, 1'b0}, '{8'h70, 1'b1, 8'h01, 8'h01, 1'b0},
    '{8'h00, 1'b1, 8'haa, 8'h00, 1'b1}, '{8'hfc, 1'b0, 8'h00, 8'h00, 1'b1},
    '{8'h84, 1'b1, 8'ha5, 8'ha5, 1'b0}};

  always #25 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (gain_seq_trigger_out === 1'b1) trigs <= trigs + 1;
    if (timeout_irq_out === 1'b1) begin
      irqs <= irqs + 1;
      at <= ticks;
    end
  end

  rx_afc_preamble_timeout_regs DUT (
    .ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_mode_in,
    .bit_tick_in, .signal_level_event_in(evt[0]),
    .preamble_event_in(evt[1]), .sync_match_event_in(evt[2]),
    .gain_phase_in, .gain_preamble_en_in, .auto_correction_en_in,
    .correction_phase_start_in, .correction_update_in,
    .correction_update_value_in(16'h1234), .freq_error_valid_in,
    .freq_error_value_in(16'hfe80), .gain_seq_trigger_out,
    .freq_correction_value_out, .preamble_detector_en_out,
    .preamble_detect_length_out, .preamble_chip_error_tolerance_out,
    .timeout_irq_out
  );

  apb_host_model host (
    .ref_clk_in, .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in),
    .prdata_in(prdata_out), .pready_in(pready_out), .pslverr_in(pslverr_out)
  );

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    chk_rd({16'h0000, got}, {16'h0000, exp});
  endtask : chk_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(a, 1'b1, d, q, e);
  endtask : wr

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : wait_n

  // Strobe 0 is phase start, 1 algorithm update, 2 error valid.
  task automatic pulse(input int k);
    @(posedge ref_clk_in);
    correction_phase_start_in <= (k == 0);
    correction_update_in <= (k == 1);
    freq_error_valid_in <= (k == 2);
    @(posedge ref_clk_in);
    correction_phase_start_in <= 1'b0;
    correction_update_in <= 1'b0;
    freq_error_valid_in <= 1'b0;
  endtask : pulse

  task automatic give_verdict;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #2ms;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    wait_n(1);
    chk_out({8'h00, preamble_detector_en_out, preamble_detect_length_out,
             preamble_chip_error_tolerance_out}, 16'h0040);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      host.xfer(rows[i].a, 1'b0, 8'h00, q, e);
      chk_rd({e, q[30:0]}, {rows[i].e, 23'h0, rows[i].q});
    end
    $display("register table done");
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h8001);
    wr(8'h68, 8'h02);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h8001);
    @(posedge ref_clk_in);
    rx_mode_in <= 1'b1;
    wr(8'h68, 8'h02);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h0000);
    wr(8'h6c, 8'h7f);
    wr(8'h68, 8'h01);
    pulse(0);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h7f00);
    @(posedge ref_clk_in);
    auto_correction_en_in <= 1'b1;
    pulse(0);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h0000);
    wr(8'h68, 8'h00);
    wr(8'h6c, 8'h7f);
    pulse(0);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h7f00);
    pulse(1);
    wr(8'h6c, 8'h55);
    wait_n(3);
    chk_out(freq_correction_value_out, 16'h5534);
    pulse(2);
    host.xfer(8'h74, 1'b0, 8'h00, q, e);
    chk_rd(q, 32'h000000fe);
    host.xfer(8'h78, 1'b0, 8'h00, q, e);
    chk_rd(q, 32'h00000080);
    $display("correction and error done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h7c, {1'b1, i[1:0], 5'h1f - i[4:0]});
      wait_n(2);
      chk_out({8'h00, preamble_detector_en_out, preamble_detect_length_out,
               preamble_chip_error_tolerance_out},
              {8'h00, 1'b1, i[1:0], 5'h1f - i[4:0]});
    end
    wr(8'h7c, 8'h40);
    gain_phase_in <= 1'b1;
    gain_preamble_en_in <= 1'b1;
    wait_n(3);
    chk_out({15'h0, preamble_detector_en_out}, 16'h0001);
    @(posedge ref_clk_in);
    gain_phase_in <= 1'b0;
    wait_n(3);
    chk_out({15'h0, preamble_detector_en_out}, 16'h0000);
    wr(8'h68, 8'h10);
    wr(8'h68, 8'h10);
    wait_n(2);
    chk_out(16'(trigs), 16'h0003);
    $display("preamble and trigger done");
    // Channel 3 leaves every limit at zero, so no timeout may fire.
    for (int ch = 0; ch < 4; ch++) begin
      for (int ev = 0; ev < 2; ev++) begin
        wr(8'h80, {7'h0, ch == 0});
        wr(8'h84, {7'h0, ch == 1});
        wr(8'h88, {7'h0, ch == 2});
        @(posedge ref_clk_in);
        rx_mode_in <= 1'b0;
        wait_n(2);
        n0 = irqs;
        @(posedge ref_clk_in);
        rx_mode_in <= 1'b1;
        ticks <= 0;
        for (int i = 0; i < 20; i++) begin
          wait_n(2);
          @(posedge ref_clk_in);
          bit_tick_in <= 1'b1;
          ticks <= ticks + 1;
          evt <= (ev == 1 && i == 5) ? 3'h7 : 3'h0;
          @(posedge ref_clk_in);
          bit_tick_in <= 1'b0;
          evt <= 3'h0;
        end
        wait_n(6);
        chk_out(16'(irqs - n0), {15'h0, ch < 3 && ev == 0});
        if (ch < 3 && ev == 0) chk_out(16'(at), 16'h0010);
      end
    end
    $display("timeouts done");
    give_verdict();
  end
endmodule : rx_afc_preamble_timeout_regs_tb

// >>> verilog/freq_correction_unit.sv
// Purpose: Holds the applied frequency correction value.
// Assumes: Controls arrive as one-cycle pulses on the register clock.
// Notes: Host writes win over clears, clears over algorithm updates.
`timescale 1ns/10ps
module freq_correction_unit (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Host access
  input wire logic wr_high_in,
  input wire logic wr_low_in,
  input wire logic [7:0] wdata_in,
  input wire logic clear_req_in,
  // Receiver side
  input wire logic rx_mode_in,
  input wire logic auto_en_in,
  input wire logic auto_clear_en_in,
  input wire logic phase_start_in,
  input wire logic update_in,
  input wire logic [15:0] update_value_in,
  // Result
  output logic [15:0] value_out
);
  import rx_afc_pkg::*;

  logic [15:0] value_reg, value_next;
  assign value_out = value_reg;

  always_comb begin
    value_next = value_reg;
    if (update_in) begin
      value_next = update_value_in;
    end
    if (auto_en_in && auto_clear_en_in && phase_start_in) begin
      value_next = '0;
    end
    if (clear_req_in && rx_mode_in) begin
      value_next = '0;
    end
    if (wr_high_in) begin
      value_next[15:8] = wdata_in;
    end
    if (wr_low_in) begin
      value_next[7:0] = wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_reg <= '0;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule : freq_correction_unit

// >>> verilog/rx_afc_preamble_timeout_regs.sv
// Purpose: Register bank for correction, preamble detect and rx timeouts.
// Assumes: Receiver events and bit ticks come from logic on ref_clk_in.
// Notes: APB slave answers with pready in the first access cycle.
`timescale 1ns/10ps
module rx_afc_preamble_timeout_regs (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rx_afc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [rx_afc_pkg::DATA_W-1:0] pwdata_in,
  output logic [rx_afc_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Receiver status
  input wire logic rx_mode_in,
  input wire logic bit_tick_in,
  input wire logic signal_level_event_in,
  input wire logic preamble_event_in,
  input wire logic sync_match_event_in,
  // Gain and correction engine
  input wire logic gain_phase_in,
  input wire logic gain_preamble_en_in,
  input wire logic auto_correction_en_in,
  input wire logic correction_phase_start_in,
  input wire logic correction_update_in,
  input wire logic [15:0] correction_update_value_in,
  input wire logic freq_error_valid_in,
  input wire logic [15:0] freq_error_value_in,
  // Controls to the receiver
  output logic gain_seq_trigger_out,
  output logic [15:0] freq_correction_value_out,
  output logic preamble_detector_en_out,
  output logic [1:0] preamble_detect_length_out,
  output logic [4:0] preamble_chip_error_tolerance_out,
  output logic timeout_irq_out
);
  import rx_afc_pkg::*;

  // Bus decode.
  logic setup_phase;
  logic wr_commit;
  logic [IDX_W-1:0] index;
  logic addr_mapped;
  logic [7:0] wbyte;

  assign setup_phase = psel_in && !penable_in;
  assign wr_commit = psel_in && penable_in && pready_out && pwrite_in;
  assign index = paddr_in[IDX_LSB +: IDX_W];
  assign wbyte = pwdata_in[7:0];

  always_comb begin
    unique case (index)
      IDX_RES_A, IDX_RES_B, IDX_RES_C, IDX_CORR_CTRL, IDX_CORR_HIGH,
      IDX_CORR_LOW, IDX_ERR_HIGH, IDX_ERR_LOW, IDX_PRE_CFG,
      IDX_TMO_LEVEL, IDX_TMO_PRE, IDX_TMO_SYNC: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  logic wr_ok;
  logic wr_ctrl, wr_corr_hi, wr_corr_lo, wr_err_hi, wr_err_lo, wr_pre;
  logic wr_res_a, wr_res_b, wr_res_c, wr_tmo_l, wr_tmo_p, wr_tmo_s;

  assign wr_ok = wr_commit && addr_mapped;
  assign wr_res_a = wr_ok && index == IDX_RES_A;
  assign wr_res_b = wr_ok && index == IDX_RES_B;
  assign wr_res_c = wr_ok && index == IDX_RES_C;
  assign wr_ctrl = wr_ok && index == IDX_CORR_CTRL;
  assign wr_corr_hi = wr_ok && index == IDX_CORR_HIGH;
  assign wr_corr_lo = wr_ok && index == IDX_CORR_LOW;
  assign wr_err_hi = wr_ok && index == IDX_ERR_HIGH;
  assign wr_err_lo = wr_ok && index == IDX_ERR_LOW;
  assign wr_pre = wr_ok && index == IDX_PRE_CFG;
  assign wr_tmo_l = wr_ok && index == IDX_TMO_LEVEL;
  assign wr_tmo_p = wr_ok && index == IDX_TMO_PRE;
  assign wr_tmo_s = wr_ok && index == IDX_TMO_SYNC;

  // Stored registers.
  logic [7:0] res_a_reg, res_a_next;
  logic [7:0] res_b_reg, res_b_next;
  logic [7:0] res_c_reg, res_c_next;
  logic ctrl_rsvd_reg, ctrl_rsvd_next;
  logic auto_clear_reg, auto_clear_next;
  logic [15:0] err_reg, err_next;
  logic [7:0] pre_cfg_reg, pre_cfg_next;
  logic [7:0] tmo_l_reg, tmo_l_next;
  logic [7:0] tmo_p_reg, tmo_p_next;
  logic [7:0] tmo_s_reg, tmo_s_next;
  logic [15:0] corr_value;

  always_comb begin
    // Reserved bytes stay writable; software is trusted to keep them.
    res_a_next = wr_res_a ? wbyte : res_a_reg;
    res_b_next = wr_res_b ? wbyte : res_b_reg;
    res_c_next = wr_res_c ? wbyte : res_c_reg;
    ctrl_rsvd_next = wr_ctrl ? wbyte[CTRL_RSVD_BIT] : ctrl_rsvd_reg;
    auto_clear_next = wr_ctrl ? wbyte[CTRL_AUTO_BIT] : auto_clear_reg;
    err_next = err_reg;
    if (freq_error_valid_in) begin
      err_next = freq_error_value_in;
    end
    if (wr_err_hi) begin
      err_next[15:8] = wbyte;
    end
    if (wr_err_lo) begin
      err_next[7:0] = wbyte;
    end
    pre_cfg_next = wr_pre ? wbyte : pre_cfg_reg;
    tmo_l_next = wr_tmo_l ? wbyte : tmo_l_reg;
    tmo_p_next = wr_tmo_p ? wbyte : tmo_p_reg;
    tmo_s_next = wr_tmo_s ? wbyte : tmo_s_reg;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_a_reg <= RES_A_RESET;
      res_b_reg <= RES_B_RESET;
      res_c_reg <= RES_C_RESET;
      ctrl_rsvd_reg <= 1'b0;
      auto_clear_reg <= 1'b0;
      err_reg <= '0;
      pre_cfg_reg <= PRE_CFG_RESET;
      tmo_l_reg <= ZERO_BYTE;
      tmo_p_reg <= ZERO_BYTE;
      tmo_s_reg <= ZERO_BYTE;
    end else begin
      res_a_reg <= res_a_next;
      res_b_reg <= res_b_next;
      res_c_reg <= res_c_next;
      ctrl_rsvd_reg <= ctrl_rsvd_next;
      auto_clear_reg <= auto_clear_next;
      err_reg <= err_next;
      pre_cfg_reg <= pre_cfg_next;
      tmo_l_reg <= tmo_l_next;
      tmo_p_reg <= tmo_p_next;
      tmo_s_reg <= tmo_s_next;
    end
  end

  // Correction value, with clear and auto-clear handled inside.
  freq_correction_unit u_corr (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .wr_high_in(wr_corr_hi),
    .wr_low_in(wr_corr_lo),
    .wdata_in(wbyte),
    .clear_req_in(wr_ctrl && wbyte[CTRL_CLEAR_BIT]),
    .rx_mode_in(rx_mode_in),
    .auto_en_in(auto_correction_en_in),
    .auto_clear_en_in(auto_clear_reg),
    .phase_start_in(correction_phase_start_in),
    .update_in(correction_update_in),
    .update_value_in(correction_update_value_in),
    .value_out(corr_value)
  );

  // Receive timeouts.
  logic rx_mode_d_reg, rx_mode_d_next;
  logic rx_entry;

  assign rx_entry = rx_mode_in && !rx_mode_d_reg;

  rx_timeout_if tmo_level ();
  rx_timeout_if tmo_pre ();
  rx_timeout_if tmo_sync ();

  assign tmo_level.rx_entry = rx_entry;
  assign tmo_level.bit_tick = bit_tick_in;
  assign tmo_level.awaited_event = signal_level_event_in;
  assign tmo_level.limit = tmo_l_reg;
  assign tmo_pre.rx_entry = rx_entry;
  assign tmo_pre.bit_tick = bit_tick_in;
  assign tmo_pre.awaited_event = preamble_event_in;
  assign tmo_pre.limit = tmo_p_reg;
  assign tmo_sync.rx_entry = rx_entry;
  assign tmo_sync.bit_tick = bit_tick_in;
  assign tmo_sync.awaited_event = sync_match_event_in;
  assign tmo_sync.limit = tmo_s_reg;

  rx_timeout_counter u_tmo_level (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .tmo(tmo_level)
  );
  rx_timeout_counter u_tmo_pre (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .tmo(tmo_pre)
  );
  rx_timeout_counter u_tmo_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .tmo(tmo_sync)
  );

  // Read mux and registered outputs.
  logic [7:0] rbyte;
  logic [DATA_W-1:0] prdata_next;
  logic pready_next, pslverr_next;
  logic gain_next, pre_en_next, irq_next;
  logic [1:0] pre_len_next;
  logic [4:0] pre_tol_next;
  logic [15:0] corr_out_next;

  always_comb begin
    rbyte = ZERO_BYTE;
    unique case (index)
      IDX_RES_A: rbyte = res_a_reg;
      IDX_RES_B: rbyte = res_b_reg;
      IDX_RES_C: rbyte = res_c_reg;
      IDX_CORR_CTRL: begin
        // Trigger bits are pulses and always read back as zero.
        rbyte[CTRL_RSVD_BIT] = ctrl_rsvd_reg;
        rbyte[CTRL_AUTO_BIT] = auto_clear_reg;
      end
      IDX_CORR_HIGH: rbyte = corr_value[15:8];
      IDX_CORR_LOW: rbyte = corr_value[7:0];
      IDX_ERR_HIGH: rbyte = err_reg[15:8];
      IDX_ERR_LOW: rbyte = err_reg[7:0];
      IDX_PRE_CFG: rbyte = pre_cfg_reg;
      IDX_TMO_LEVEL: rbyte = tmo_l_reg;
      IDX_TMO_PRE: rbyte = tmo_p_reg;
      IDX_TMO_SYNC: rbyte = tmo_s_reg;
      default: rbyte = ZERO_BYTE;
    endcase
  end

  always_comb begin
    rx_mode_d_next = rx_mode_in;
    pready_next = setup_phase;
    prdata_next = prdata_out;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      prdata_next = {{(DATA_W-8){1'b0}}, rbyte};
      pslverr_next = !addr_mapped;
    end
    gain_next = wr_ctrl && wbyte[CTRL_GAIN_BIT];
    // The gain phase owns the detector enable until it finishes.
    pre_en_next = gain_phase_in ? gain_preamble_en_in
                                : pre_cfg_reg[PRE_EN_BIT];
    pre_len_next = pre_cfg_reg[PRE_LEN_HI:PRE_LEN_LO];
    pre_tol_next = pre_cfg_reg[PRE_TOL_HI:PRE_TOL_LO];
    corr_out_next = corr_value;
    irq_next = tmo_level.expired || tmo_pre.expired || tmo_sync.expired;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_mode_d_reg <= 1'b0;
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      gain_seq_trigger_out <= 1'b0;
      preamble_detector_en_out <= 1'b0;
      preamble_detect_length_out <= '0;
      preamble_chip_error_tolerance_out <= '0;
      freq_correction_value_out <= '0;
      timeout_irq_out <= 1'b0;
    end else begin
      rx_mode_d_reg <= rx_mode_d_next;
      prdata_out <= prdata_next;
      pready_out <= pready_next;
      pslverr_out <= pslverr_next;
      gain_seq_trigger_out <= gain_next;
      preamble_detector_en_out <= pre_en_next;
      preamble_detect_length_out <= pre_len_next;
      preamble_chip_error_tolerance_out <= pre_tol_next;
      freq_correction_value_out <= corr_out_next;
      timeout_irq_out <= irq_next;
    end
  end
endmodule : rx_afc_preamble_timeout_regs

// >>> verilog/rx_timeout_counter.sv
// Purpose: One receive timeout, counted in bit periods.
// Assumes: bit_tick pulses once per bit period.
// Notes: expired is a one-cycle pulse.
`timescale 1ns/10ps
module rx_timeout_counter (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Channel
  rx_timeout_if.cnt tmo
);
  import rx_afc_pkg::*;

  logic run_reg, run_next;
  logic [TMO_W-1:0] count_reg, count_next;
  logic expired_reg, expired_next;
  logic [TMO_W-1:0] target;

  assign target = {tmo.limit, {TMO_SHIFT{1'b0}}};
  assign tmo.expired = expired_reg;

  always_comb begin
    run_next = run_reg;
    count_next = count_reg;
    expired_next = 1'b0;
    if (tmo.rx_entry) begin
      run_next = 1'b1;
      count_next = '0;
    end else if (tmo.awaited_event) begin
      run_next = 1'b0;
    end else if (run_reg && tmo.bit_tick && tmo.limit != ZERO_BYTE) begin
      count_next = count_reg + 1'b1;
      if (count_next == target) begin
        expired_next = 1'b1;
        run_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_reg <= 1'b0;
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end
endmodule : rx_timeout_counter
